// file: icp_consts.svh
// constants of the configuration port and alarm monitors
`ifndef ICP_CONSTS_SVH
`define ICP_CONSTS_SVH
`define ICP_ADDR_FIXED 5'h1B
`define ICP_NREG 24
`define ICP_REG_LAST 8'h17
`define ICP_REG_LFD_HI0 5'h0A
`define ICP_REG_LFD_MID0 5'h0C
`define ICP_REG_LFD_LO0 5'h0E
`define ICP_REG_QTYPE0 5'h12
`define ICP_REG_GLOBAL 5'h14
`define ICP_BIT_QTYPE 0
`define ICP_BIT_MODE_HI 7
`define ICP_BIT_MODE_LO 6
`define ICP_BIT_CONFIG 5
`define ICP_BIT_CFG_PIN_REG 4
`define ICP_BIT_OE 2
`define ICP_BIT_HOLDOVER 6
`define ICP_BIT_REF_BAD 4
`define ICP_BIT_XTAL_MISS 3
`define ICP_BIT_LOCK 2
`define ICP_GLOBAL_RST 8'h04
`define ICP_MODE_LOW_BW 2'h2
`define ICP_MISS_EDGES 2'h3
`define ICP_FIFO_DEPTH 8
`endif

// file: icp_pkg.sv
// types of the configuration port and alarm monitors
`include "icp_consts.svh"
package icp_pkg;
	typedef enum logic [3:0] {
		ICP_IDLE, ICP_ADDR, ICP_ADDR_ACK, ICP_REG, ICP_REG_ACK,
		ICP_WDATA, ICP_WACK, ICP_RDATA, ICP_RACK
	} icp_i2c_st_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic strap_lo;
		logic strap_hi;
		logic oe;
		logic cfg_sel;
		logic lock;
		logic xtal;
		logic ref_raw;
		logic ref_div;
		logic fb_up;
		logic fb_lo;
	} icp_pins_t;

	typedef struct packed {
		logic [4:0] idx;
		logic [7:0] data;
	} icp_wr_t;

	typedef struct packed {
		icp_pins_t s1;
		icp_pins_t s2;
		icp_pins_t s3;
		icp_i2c_st_t st;
		logic [7:0] sr;
		logic [3:0] cnt;
		logic rw;
		logic [7:0] ptr;
		logic sda_oe;
		logic [1:0] xcnt;
		logic [1:0] rcnt;
		logic xbad;
		logic rbad;
		logic [`ICP_NREG-1:0][7:0] regs;
	} icp_core_t;
endpackage

// file: icp_config_port.sv
// serial configuration port, write buffer and alarm monitors
`timescale 1ns/10ps
`default_nettype none
`include "icp_consts.svh"

module icp_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = `ICP_FIFO_DEPTH
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] rp;
		logic [AW-1:0] wp;
		logic [AW:0] used;
	} icp_fifo_st_t;
	icp_fifo_st_t f_q, f_d;
	logic push, pop;

	assign in_ready = (f_q.used != (AW+1)'(DEPTH));
	assign out_valid = (f_q.used != '0);
	assign out_data = f_q.mem[f_q.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		f_d = f_q;
		if (push) begin
			f_d.mem[f_q.wp] = in_data;
			f_d.wp = (f_q.wp == AW'(DEPTH-1)) ? '0 : f_q.wp + 1'b1;
		end
		if (pop)
			f_d.rp = (f_q.rp == AW'(DEPTH-1)) ? '0 : f_q.rp + 1'b1;
		if (push && !pop)
			f_d.used = f_q.used + 1'b1;
		else if (pop && !push)
			f_d.used = f_q.used - 1'b1;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			f_q <= '0;
		else
			f_q <= f_d;
	end
endmodule // icp_fifo

module icp_config_port (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// serial link
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// straps and control pins
	input wire logic addr_strap_low,
	input wire logic addr_strap_high,
	input wire logic oe_pin,
	input wire logic config_pin,
	// monitored clocks and loop state
	input wire logic xtal_clk,
	input wire logic ref_clk,
	input wire logic ref_div_clk,
	input wire logic fb_upper,
	input wire logic fb_lower,
	input wire logic pll_freq_lock,
	// write buffer drain stall
	input wire logic reg_wr_hold,
	// status
	output logic pll_locked_flag,
	output logic crystal_missing_alarm,
	output logic ref_missing_alarm,
	output logic holdover_flag,
	output logic phase_adjust_en,
	output logic holdover_track_osc,
	output logic free_run,
	// output stage and loop settings
	output logic out_drv_en,
	output logic out_hiz,
	output logic out_lvds,
	output logic [1:0] mode_sel,
	output logic [16:0] lower_loop_feedback_divider
);
	icp_pkg::icp_core_t c_q, c_d;
	icp_pkg::icp_pins_t pins;
	icp_pkg::icp_wr_t wr_in, wr_out;
	logic scl_rise, scl_fall, start_c, stop_c;
	logic xtal_edge, ref_edge, refd_edge, fb_edge, fbu_edge, low_bw;
	logic wr_valid, wr_ready, rd_valid, cfg1;
	logic [7:0] status_byte, rd_byte;
	logic [4:0] cfg_off;

	assign pins = '{scl: scl_in, sda: sda_in, strap_lo: addr_strap_low,
		strap_hi: addr_strap_high, oe: oe_pin, cfg_sel: config_pin,
		lock: pll_freq_lock, xtal: xtal_clk, ref_raw: ref_clk,
		ref_div: ref_div_clk, fb_up: fb_upper, fb_lo: fb_lower};

	// edges seen between the second and third stages
	assign scl_rise = c_q.s2.scl && !c_q.s3.scl;
	assign scl_fall = !c_q.s2.scl && c_q.s3.scl;
	assign start_c = c_q.s2.scl && c_q.s3.scl && !c_q.s2.sda && c_q.s3.sda;
	assign stop_c = c_q.s2.scl && c_q.s3.scl && c_q.s2.sda && !c_q.s3.sda;
	assign xtal_edge = c_q.s2.xtal && !c_q.s3.xtal;
	assign ref_edge = c_q.s2.ref_raw && !c_q.s3.ref_raw;
	assign refd_edge = c_q.s2.ref_div && !c_q.s3.ref_div;
	assign fbu_edge = c_q.s2.fb_up && !c_q.s3.fb_up;
	assign mode_sel = {c_q.regs[`ICP_REG_GLOBAL][`ICP_BIT_MODE_HI],
		c_q.regs[`ICP_REG_GLOBAL][`ICP_BIT_MODE_LO]};
	assign low_bw = (mode_sel == `ICP_MODE_LOW_BW);
	// feedback of the loop the reference actually drives
	assign fb_edge = low_bw ? (c_q.s2.fb_lo && !c_q.s3.fb_lo) : fbu_edge;

	// lock and crystal alarm run the same in every mode; reference alarm feedback, holdover_track_osc and free_run follow low_bw
	assign pll_locked_flag = c_q.s2.lock;
	assign crystal_missing_alarm = c_q.xbad;
	assign ref_missing_alarm = c_q.rbad;
	assign holdover_flag = !c_q.s2.lock || c_q.rbad;
	assign phase_adjust_en = !c_q.rbad;
	assign holdover_track_osc = c_q.rbad && low_bw;
	assign free_run = c_q.rbad && !low_bw;

	// configuration select, register or pin
	assign cfg1 = c_q.regs[`ICP_REG_GLOBAL][`ICP_BIT_CFG_PIN_REG] ?
		c_q.regs[`ICP_REG_GLOBAL][`ICP_BIT_CONFIG] : c_q.s2.cfg_sel;
	assign cfg_off = {4'h0, cfg1};
	assign out_lvds = c_q.regs[`ICP_REG_QTYPE0 + cfg_off][`ICP_BIT_QTYPE];
	assign lower_loop_feedback_divider = {
		c_q.regs[`ICP_REG_LFD_HI0 + cfg_off][4:0],
		c_q.regs[`ICP_REG_LFD_MID0 + cfg_off],
		c_q.regs[`ICP_REG_LFD_LO0 + cfg_off][7:4]};
	assign out_drv_en = c_q.regs[`ICP_REG_GLOBAL][`ICP_BIT_OE] && c_q.s2.oe;
	assign out_hiz = !out_drv_en;

	assign status_byte = {1'b0, holdover_flag, 1'b0, c_q.rbad, c_q.xbad,
		c_q.s2.lock, 2'b00};
	assign rd_byte = (c_q.ptr < `ICP_REG_LAST) ? c_q.regs[c_q.ptr[4:0]] :
		(c_q.ptr == `ICP_REG_LAST) ? status_byte : 8'h00;

	assign sda_out = 1'b0;
	assign sda_oe = c_q.sda_oe;
	// a data byte below the status byte is only acked when the buffer can take it
	// bytes at or past the status byte are acked but never queued: the index would wrap
	assign wr_valid = (c_q.st == icp_pkg::ICP_WDATA) && scl_fall && (c_q.cnt == 4'h8) &&
		(c_q.ptr < `ICP_REG_LAST);
	assign wr_in = '{idx: c_q.ptr[4:0], data: c_q.sr};

	icp_fifo #(.WIDTH($bits(icp_pkg::icp_wr_t)), .DEPTH(`ICP_FIFO_DEPTH)) u_wr_fifo (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data(wr_in),
		.out_valid(rd_valid),
		.out_ready(!reg_wr_hold),
		.out_data(wr_out)
	);

	always_comb begin
		c_d = c_q;
		c_d.s1 = pins;
		c_d.s2 = c_q.s1;
		c_d.s3 = c_q.s2;
		// crystal monitor, crystal edge wins over feedback
		if (xtal_edge) begin
			c_d.xcnt = 2'h0;
			c_d.xbad = 1'b0;
		end else if (fbu_edge && c_q.xcnt != `ICP_MISS_EDGES) begin
			c_d.xcnt = c_q.xcnt + 2'h1;
			if (c_q.xcnt == `ICP_MISS_EDGES - 2'h1)
				c_d.xbad = 1'b1;
		end
		// reference monitor
		// a live raw reference restarts the count, else the alarm could never return
		if (refd_edge || ref_edge)
			c_d.rcnt = 2'h0;
		else if (fb_edge && c_q.rcnt != `ICP_MISS_EDGES) begin
			c_d.rcnt = c_q.rcnt + 2'h1;
			if (c_q.rcnt == `ICP_MISS_EDGES - 2'h1)
				c_d.rbad = 1'b1;
		end
		if (ref_edge || refd_edge)
			c_d.rbad = 1'b0;
		// drain buffered writes; status byte and beyond are not writable
		if (rd_valid && !reg_wr_hold && wr_out.idx < `ICP_REG_LAST)
			c_d.regs[wr_out.idx] = wr_out.data;
		// serial protocol
		if (start_c) begin
			c_d.st = icp_pkg::ICP_ADDR;
			c_d.cnt = 4'h0;
			c_d.sda_oe = 1'b0;
		end else if (stop_c) begin
			c_d.st = icp_pkg::ICP_IDLE;
			c_d.sda_oe = 1'b0;
		end else begin
			unique case (c_q.st)
				icp_pkg::ICP_IDLE: begin
				end
				icp_pkg::ICP_ADDR, icp_pkg::ICP_REG, icp_pkg::ICP_WDATA: begin
					if (scl_rise && c_q.cnt != 4'h8) begin
						c_d.sr = {c_q.sr[6:0], c_q.s2.sda};
						c_d.cnt = c_q.cnt + 4'h1;
					end else if (scl_fall && c_q.cnt == 4'h8) begin
						c_d.cnt = 4'h0;
						if (c_q.st == icp_pkg::ICP_ADDR) begin
							if (c_q.sr[7:3] == `ICP_ADDR_FIXED &&
								c_q.sr[2:1] == {c_q.s2.strap_hi, c_q.s2.strap_lo}) begin
								c_d.rw = c_q.sr[0];
								c_d.sda_oe = 1'b1;
								c_d.st = icp_pkg::ICP_ADDR_ACK;
							end else
								c_d.st = icp_pkg::ICP_IDLE;
						end else if (c_q.st == icp_pkg::ICP_REG) begin
							c_d.ptr = c_q.sr;
							c_d.sda_oe = 1'b1;
							c_d.st = icp_pkg::ICP_REG_ACK;
						end else if (wr_ready || c_q.ptr >= `ICP_REG_LAST) begin
							c_d.ptr = c_q.ptr + 8'h01;
							c_d.sda_oe = 1'b1;
							c_d.st = icp_pkg::ICP_WACK;
						end else
							c_d.st = icp_pkg::ICP_IDLE;
					end
				end
				icp_pkg::ICP_ADDR_ACK, icp_pkg::ICP_REG_ACK, icp_pkg::ICP_WACK: begin
					if (scl_fall) begin
						c_d.sda_oe = 1'b0;
						if (c_q.st == icp_pkg::ICP_ADDR_ACK && c_q.rw) begin
							c_d.sr = rd_byte;
							c_d.sda_oe = !rd_byte[7];
							c_d.st = icp_pkg::ICP_RDATA;
						end else
							c_d.st = (c_q.st == icp_pkg::ICP_ADDR_ACK) ?
								icp_pkg::ICP_REG : icp_pkg::ICP_WDATA;
					end
				end
				icp_pkg::ICP_RDATA: begin
					if (scl_fall) begin
						if (c_q.cnt == 4'h7) begin
							c_d.sda_oe = 1'b0;
							c_d.cnt = 4'h0;
							c_d.st = icp_pkg::ICP_RACK;
						end else begin
							c_d.sr = {c_q.sr[6:0], 1'b0};
							c_d.sda_oe = !c_q.sr[6];
							c_d.cnt = c_q.cnt + 4'h1;
						end
					end
				end
				icp_pkg::ICP_RACK: begin
					if (scl_rise) begin
						c_d.ptr = c_q.ptr + 8'h01;
						c_d.rw = !c_q.s2.sda;
					end else if (scl_fall) begin
						if (c_q.rw) begin
							c_d.sr = rd_byte;
							c_d.sda_oe = !rd_byte[7];
							c_d.st = icp_pkg::ICP_RDATA;
						end else
							c_d.st = icp_pkg::ICP_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			c_q <= '0;
			c_q.regs[`ICP_REG_GLOBAL] <= `ICP_GLOBAL_RST;
			c_q.st <= icp_pkg::ICP_IDLE;
		end else
			c_q <= c_d;
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	chk_xtal_alarm_set: assert property (!xtal_edge && fbu_edge && c_q.xcnt == 2'h2
		|=> crystal_missing_alarm) else $error("crystal alarm missed third edge");
	chk_xtal_alarm_clr: assert property (xtal_edge |=> !crystal_missing_alarm)
		else $error("crystal alarm not cleared by crystal edge");
	chk_ref_alarm_set: assert property (!ref_edge && !refd_edge && fb_edge &&
		c_q.rcnt == 2'h2 |=> ref_missing_alarm) else $error("reference alarm late");
	chk_ref_alarm_clr: assert property (ref_edge |=> !ref_missing_alarm)
		else $error("reference alarm not cleared");
	chk_lock_follow: assert property ($fell(c_q.s1.lock) |=> !pll_locked_flag && holdover_flag)
		else $error("lock flag outlived lock");
	chk_holdover_mode: assert property (ref_missing_alarm |-> holdover_flag && !phase_adjust_en
		&& (holdover_track_osc != free_run)) else $error("holdover outputs wrong");
	chk_oe_gate: assert property (!c_q.s2.oe || !c_q.regs[`ICP_REG_GLOBAL][`ICP_BIT_OE]
		|-> out_hiz && !out_drv_en) else $error("output enabled while gated off");
	chk_addr_nack: assert property (c_q.st == icp_pkg::ICP_ADDR && scl_fall && c_q.cnt == 4'h8
		&& c_q.sr[7:3] != `ICP_ADDR_FIXED && !start_c && !stop_c
		|=> !sda_oe [*2]) else $error("foreign address acknowledged");
	chk_ptr_step: assert property (wr_valid && wr_ready && !start_c && !stop_c
		|=> c_q.ptr == $past(c_q.ptr) + 8'h01) else $error("pointer not advanced");

	cov_write_byte: cover property (c_q.st == icp_pkg::ICP_WACK ##[1:400] c_q.st == icp_pkg::ICP_WDATA);
	cov_read_byte: cover property (c_q.st == icp_pkg::ICP_RACK ##[1:400] c_q.st == icp_pkg::ICP_RDATA);
	cov_fifo_full: cover property (wr_valid && !wr_ready);
	cov_ref_lost: cover property ($rose(ref_missing_alarm) ##[1:1000] $fell(ref_missing_alarm));
endmodule // icp_config_port
`default_nettype wire

// file: icp_mst.sv
// bit-level serial bus master standing in for the host
`timescale 1ns/10ps
`default_nettype none
module icp_mst (
	// clock
	input wire logic mclk,
	// serial link
	output logic scl,
	output logic sda_pull,
	input wire logic sda
);
	// quarter bit in mclk cycles; bench may slow it down
	int hp = 8;
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// data only moves while the clock is low
	task automatic bit_x(input logic b, output logic r);
		sda_pull <= !b;
		step(hp);
		scl <= 1'b1;
		step(hp);
		r = sda;
		step(hp);
		scl <= 1'b0;
		step(hp);
	endtask
	// also used as repeated start
	task automatic start();
		sda_pull <= 1'b0;
		step(hp);
		scl <= 1'b1;
		step(hp);
		sda_pull <= 1'b1;
		step(hp);
		scl <= 1'b0;
		step(hp);
	endtask
	task automatic stop();
		sda_pull <= 1'b1;
		step(hp);
		scl <= 1'b1;
		step(hp);
		sda_pull <= 1'b0;
		step(hp);
	endtask
	// ab: level the master gives on the ninth bit
	task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] r,
		output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r[i]);
		bit_x(ab, a);
		ack = !a;
	endtask
	// idle link: clock stands high, data released to its pull-up
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
endmodule // icp_mst
`default_nettype wire

// file: icp_config_port_tb_top.sv
// self-checking bench for the configuration port and alarm monitors
`timescale 1ns/10ps
`default_nettype none
module icp_config_port_tb_top;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] clks = 5'h00; // xtal, ref, ref div, upper fb, lower fb
	logic [1:0] strap = 2'h0;
	logic oe_pin = 1'b1, config_pin = 1'b0, lock = 1'b0, hold = 1'b0;
	logic scl, m_pull, sda_w, sda_out, sda_oe, ack;
	logic locked, xbad, rbad, hov, padj, trk, frun, drv, hiz, lvds;
	logic e_x = 1'b0, e_r = 1'b0, e_l = 1'b0;
	logic [1:0] mode;
	logic [16:0] div;
	logic [7:0] rbyte;
	logic [7:0] shadow [24];
	logic [7:0] wd [24];
	int n_fail = 0, samples_checked = 0, cycles = 0;
	// open-drain line with pull-up
	assign sda_w = !(m_pull | (sda_oe & !sda_out));
	icp_mst icp_mst_i (.mclk(mclk), .scl(scl), .sda_pull(m_pull), .sda(sda_w));
	icp_config_port icp_config_port_i (
		.mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe(sda_oe), .addr_strap_low(strap[0]), .addr_strap_high(strap[1]),
		.oe_pin(oe_pin), .config_pin(config_pin), .xtal_clk(clks[0]), .ref_clk(clks[1]),
		.ref_div_clk(clks[2]), .fb_upper(clks[3]), .fb_lower(clks[4]),
		.pll_freq_lock(lock), .reg_wr_hold(hold), .pll_locked_flag(locked),
		.crystal_missing_alarm(xbad), .ref_missing_alarm(rbad), .holdover_flag(hov),
		.phase_adjust_en(padj), .holdover_track_osc(trk), .free_run(frun),
		.out_drv_en(drv), .out_hiz(hiz), .out_lvds(lvds), .mode_sel(mode),
		.lower_loop_feedback_divider(div)
	);
	initial begin
		forever #2.5 mclk = !mclk;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("mismatch at %0t got %0h expected %0h", $time, got, exp);
			n_fail++;
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	function automatic logic [7:0] sla(input logic rw);
		return {5'h1B, strap, rw};
	endfunction
	function automatic logic [16:0] div_of(input int c);
		return {shadow[10+c][4:0], shadow[12+c], shadow[14+c][7:4]};
	endfunction
	function automatic logic [7:0] exp_reg(input int p);
		if (p < 23)
			return shadow[p];
		if (p == 23)
			return {1'b0, !e_l | e_r, 1'b0, e_r, e_x, e_l, 2'h0};
		return 8'h00;
	endfunction
	// block write of wd[p..]; byte number bad is expected to be refused
	task automatic wr(input int p, input int n, input int bad);
		icp_mst_i.start();
		icp_mst_i.xfer(sla(1'b0), 1'b1, rbyte, ack);
		chk(ack, 1);
		icp_mst_i.xfer(8'(p), 1'b1, rbyte, ack);
		for (int k = 0; k < n; k++) begin
			icp_mst_i.xfer(wd[p+k], 1'b1, rbyte, ack);
			chk(ack, k != bad);
			if (k == bad)
				break;
			if (p + k < 23)
				shadow[p+k] = wd[p+k];
		end
		icp_mst_i.stop();
	endtask
	task automatic rd_chk(input int p, input int n);
		icp_mst_i.start();
		icp_mst_i.xfer(sla(1'b0), 1'b1, rbyte, ack);
		icp_mst_i.xfer(8'(p), 1'b1, rbyte, ack);
		icp_mst_i.start();
		icp_mst_i.xfer(sla(1'b1), 1'b1, rbyte, ack);
		chk(ack, 1);
		for (int k = 0; k < n; k++) begin
			icp_mst_i.xfer(8'hFF, k == n - 1, rbyte, ack);
			chk(rbyte, exp_reg(p + k));
		end
		icp_mst_i.stop();
	endtask
	task automatic pulse(input logic [4:0] m);
		clks <= clks | m;
		wt(3);
		clks <= clks & ~m;
		wt(3);
	endtask
	initial begin
		void'($urandom(32'h2E5B));
		strap <= 2'($urandom);
		for (int i = 0; i < 24; i++)
			shadow[i] = 8'h00;
		shadow[20] = 8'h04;
		wt(2);
		rst_n <= 1'b1;
		wt(6);
		chk({drv, hiz, lvds, mode, div, locked, hov}, {2'b10, 20'h0, 2'b01});
		$display("test reset done");
		for (int i = 0; i < 2; i++) begin
			icp_mst_i.start();
			icp_mst_i.xfer(i ? {5'h1A, strap, 1'b0} : {5'h1B, ~strap, 1'b0}, 1'b1, rbyte, ack);
			chk(ack, 0);
			icp_mst_i.xfer(8'h0A, 1'b1, rbyte, ack);
			chk(ack, 0);
			icp_mst_i.stop();
		end
		$display("test address done");
		for (int i = 10; i < 20; i++)
			wd[i] = 8'($urandom);
		wr(10, 10, -1);
		for (int c = 0; c < 2; c++) begin
			config_pin <= c[0];
			wt(6);
			chk(div, div_of(c));
			chk(lvds, shadow[18+c][0]);
		end
		rd_chk(10, 10);
		$display("test config done");
		for (int i = 0; i < 4; i++) begin
			wd[20] = {2'($urandom), 3'h0, i[0], 2'h0};
			wr(20, 1, -1);
			oe_pin <= i[1];
			wt(6);
			chk({drv, hiz, mode}, {i[0] & i[1], !(i[0] & i[1]), wd[20][7:6]});
		end
		// stop right after the status byte
		wd[21] = 8'($urandom);
		wd[22] = 8'($urandom);
		wd[23] = 8'hFF;
		wr(21, 3, -1);
		rd_chk(21, 4);
		$display("test output done");
		lock <= 1'b1;
		e_l = 1'b1;
		wt(6);
		chk({locked, hov}, 2'b10);
		rd_chk(23, 1);
		lock <= 1'b0;
		e_l = 1'b0;
		wt(6);
		chk({locked, hov}, 2'b01);
		for (int j = 0; j < 2; j++) begin
			wd[20] = {j ? 2'h2 : 2'h1, 6'h04};
			wr(20, 1, -1);
			pulse(5'h07);
			pulse(j ? 5'h10 : 5'h08);
			pulse(j ? 5'h10 : 5'h08);
			chk({xbad, rbad}, 0);
			pulse(j ? 5'h10 : 5'h08);
			e_x = !j[0];
			e_r = 1'b1;
			chk({xbad, rbad, hov, padj, trk, frun}, {e_x, 3'b110, j[0], !j[0]});
			rd_chk(23, 1);
			pulse(5'h02);
			e_r = 1'b0;
			chk({rbad, padj}, 2'b01);
			pulse(5'h01);
			e_x = 1'b0;
			chk(xbad, 0);
		end
		$display("test alarms done");
		icp_mst_i.hp = 12;
		hold <= 1'b1;
		for (int i = 0; i < 9; i++)
			wd[i] = 8'($urandom);
		wr(0, 9, 8);
		hold <= 1'b0;
		rd_chk(0, 8);
		$display("test buffer done");
		tally_and_finish();
	end
endmodule // icp_config_port_tb_top
`default_nettype wire
